// ### rtl/dac_irq_defs.vh
// Register map, field positions, reset values and serial framing
// constants for the control and event block.
// Assumes one 40 MHz clock and an 8-bit register file.
`ifndef DAC_IRQ_DEFS_VH
`define DAC_IRQ_DEFS_VH

// ==========================================
// Register offsets (7-bit address)
`define ADDR_SERIAL_PORT_CONFIG 7'h00
`define ADDR_POWER_DOWN_CONTROL 7'h01
`define ADDR_EVENT_ENABLE_A     7'h03
`define ADDR_EVENT_ENABLE_B     7'h04
`define ADDR_EVENT_FLAGS_A      7'h05
`define ADDR_EVENT_FLAGS_B      7'h06
`define ADDR_EVENT_ROUTE_A      7'h07
`define ADDR_EVENT_ROUTE_B      7'h08

// ==========================================
// Reset values
`define RST_SERIAL_PORT_CONFIG 8'h00
`define RST_POWER_DOWN_CONTROL 8'hc0
`define RST_EVENT_ENABLE       8'h00
`define RST_EVENT_FLAGS        8'h00
`define RST_EVENT_ROUTE        8'h00

// ==========================================
// Serial port config fields
`define BIT_LSB_FIRST  6
`define BIT_SOFT_RESET 5

// ==========================================
// Power-down fields
`define BIT_INPHASE_OFF  7
`define BIT_QUAD_OFF     6
`define BIT_RECEIVER_OFF 5
`define BIT_CHIP_OFF     2
`define BIT_CLOCK_OFF    1
`define BIT_FRAME_OFF    0

// ==========================================
// Event bit positions, bank A
`define EVT_SYNC_LOST     6
`define EVT_SYNC_LOCKED   5
`define EVT_SYNC_DONE     4
`define EVT_SYNTH_LOST    3
`define EVT_SYNTH_LOCKED  2
`define EVT_OVER_THRESH   1
`define EVT_OUT_SILENCED  0
// Event bit positions, bank B
`define EVT_FIFO_UNDER    2
`define EVT_FIFO_OVER     1
`define EVT_FIFO_WARN     0

// Implemented bits per bank
`define MASK_BANK_A 8'h7f
`define MASK_BANK_B 8'h07
`define MASK_PD     8'he7
`define MASK_CFG    8'h40

// ==========================================
// FIFO warning thresholds (slots)
`define FIFO_WARN_LOW  3'h1
`define FIFO_WARN_HIGH 3'h6

// ==========================================
// Serial framing: instruction byte, then data byte
`define SPI_BYTE_LAST 3'h7
`define SPI_READ_BIT  7

`endif

// ### rtl/dac_event_irq_and_power_ctrl.v
// Common control registers, power-down controls and event/interrupt
// logic of a dual converter, reached over a 3-wire serial port.
// Assumes serial pins are asynchronous to clk; event sources and FIFO
// pointers come from logic on clk.
//
// Operation
// - Serial bits go MSB first when bit-order bit is 0, else LSB first.
// - Writing 1 to soft reset bit resets device; bit self-clears, reads 0.
// - In-phase power-down turns off only that channel's analog part.
// - Quadrature power-down turns off only that channel's analog part.
// - Receiver power-down stops input interface and FIFO write side.
// - Whole-device power-down turns off reference and whole chip.
// - Converter clock power-down stops clock path and most digital logic.
// - Frame power-down disables frame input and holds internal frame low.
// - Enable register A holds one enable per sync, synth, power, mute event.
// - Enable register B holds FIFO underflow, overflow, warning enables.
// - Flag bits 6,5,4 set on sync lost, locked, done.
// - Flag bits 3,2 set on synthesizer lock lost and lock gained.
// - Flag bit 1 sets when input power exceeds threshold.
// - Flag bit 0 sets when converter output is muted.
// - Underflow flag sets when read pointer catches write pointer.
// - Overflow flag sets when write pointer catches read pointer.
// - Warning flag sets when fill level is at most 1 or at least 6.
// - Route bit 0 sends an event to interrupt pin A.
// - Route bit 1 sends an event to interrupt pin B.
`timescale 1ns/1ps
`include "dac_irq_defs.vh"

module dac_event_irq_and_power_ctrl
(
  input  wire       clk,
  input  wire       resetn,
  input  wire       spi_cs_n,
  input  wire       spi_sclk,
  input  wire       spi_sdio_i,
  output wire       spi_sdio_o,
  output wire       spi_sdio_oe,
  input  wire       sync_lost_evt,
  input  wire       sync_locked_evt,
  input  wire       sync_done_evt,
  input  wire       synth_lost_evt,
  input  wire       synth_locked_evt,
  input  wire       over_threshold_evt,
  input  wire       output_silenced_flag,
  input  wire [2:0] fifo_rd_ptr,
  input  wire [2:0] fifo_wr_ptr,
  input  wire       fifo_rd_adv,
  input  wire       fifo_wr_adv,
  input  wire       frame_pin,
  output wire       frame_internal,
  output wire       inphase_analog_off,
  output wire       quad_analog_off,
  output wire       input_receiver_off,
  output wire       whole_chip_off,
  output wire       converter_clock_off,
  output wire       frame_input_off,
  output wire       device_reset,
  output wire       interrupt_pin_a,
  output wire       interrupt_pin_b
);

  // ==========================================
  // Serial FSM states
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_INSTR = 3'h1;
  localparam [2:0] ST_WDATA = 3'h2;
  localparam [2:0] ST_RDATA = 3'h3;
  localparam [2:0] ST_DONE  = 3'h4;

  // Bit reversal for LSB-first framing
  function [7:0] rev8;
    input [7:0] v;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
        rev8[i] = v[7-i];
    end
  endfunction

  // ==========================================
  // Pin synchronisers
  reg  [1:0] cs_sync_q;
  reg  [2:0] sclk_sync_q;
  reg  [1:0] sdi_sync_q;
  reg  [1:0] frame_sync_q;

  // Two flops before any logic; third sclk stage for edges
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      cs_sync_q    <= 2'h3;
      sclk_sync_q  <= 3'h0;
      sdi_sync_q   <= 2'h0;
      frame_sync_q <= 2'h0;
    end
    else
    begin
      cs_sync_q    <= {cs_sync_q[0], spi_cs_n};
      sclk_sync_q  <= {sclk_sync_q[1:0], spi_sclk};
      sdi_sync_q   <= {sdi_sync_q[0], spi_sdio_i};
      frame_sync_q <= {frame_sync_q[0], frame_pin};
    end
  end

  wire cs_active = ~cs_sync_q[1];
  wire sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
  wire sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];

  // ==========================================
  // Registers
  reg  [7:0] cfg_q;
  reg  [7:0] pd_q;
  reg  [7:0] en_a_q;
  reg  [7:0] en_b_q;
  reg  [7:0] flag_a_q;
  reg  [7:0] flag_b_q;
  reg  [7:0] route_a_q;
  reg  [7:0] route_b_q;
  reg        soft_rst_q;
  reg        irq_a_q;
  reg        irq_b_q;

  // Serial engine state
  reg  [2:0] state_q;
  reg  [2:0] bit_cnt_q;
  reg  [7:0] rx_q;
  reg  [6:0] addr_q;
  reg  [7:0] tx_q;
  reg        sdo_q;
  reg        oe_q;

  wire       lsb_first = cfg_q[`BIT_LSB_FIRST];
  wire [7:0] rx_next   = {rx_q[6:0], sdi_sync_q[1]};
  wire [7:0] rx_word   = lsb_first ? rev8(rx_next) : rx_next;
  wire       byte_end  = sclk_rise & (bit_cnt_q == `SPI_BYTE_LAST);
  wire       wr_stb    = (state_q == ST_WDATA) & byte_end & cs_active;

  // Register read mux; soft reset bit always reads 0
  reg  [7:0] rd_data;
  always @*
  begin
    case (rx_word[6:0])
      `ADDR_SERIAL_PORT_CONFIG: rd_data = cfg_q & `MASK_CFG;
      `ADDR_POWER_DOWN_CONTROL: rd_data = pd_q;
      `ADDR_EVENT_ENABLE_A:     rd_data = en_a_q;
      `ADDR_EVENT_ENABLE_B:     rd_data = en_b_q;
      `ADDR_EVENT_FLAGS_A:      rd_data = flag_a_q;
      `ADDR_EVENT_FLAGS_B:      rd_data = flag_b_q;
      `ADDR_EVENT_ROUTE_A:      rd_data = route_a_q;
      `ADDR_EVENT_ROUTE_B:      rd_data = route_b_q;
      default:                  rd_data = 8'h00;
    endcase
  end

  // ==========================================
  // Serial FSM: instruction byte then one data byte
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 3'h0;
      rx_q      <= 8'h00;
      addr_q    <= 7'h00;
      tx_q      <= 8'h00;
      sdo_q     <= 1'b0;
      oe_q      <= 1'b0;
    end
    else if (!cs_active)
    begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 3'h0;
      oe_q      <= 1'b0;
    end
    else
    begin
      if (sclk_rise)
      begin
        rx_q      <= rx_next;
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      case (state_q)
        ST_IDLE:
          state_q <= ST_INSTR;
        ST_INSTR:
          if (byte_end)
          begin
            addr_q <= rx_word[6:0];
            if (rx_word[`SPI_READ_BIT])
            begin
              state_q <= ST_RDATA;
              // Pre-order the read byte for shifting MSB out
              tx_q    <= lsb_first ? rev8(rd_data) : rd_data;
            end
            else
              state_q <= ST_WDATA;
          end
        ST_WDATA:
          if (byte_end)
            state_q <= ST_DONE;
        ST_RDATA:
        begin
          // Drive next bit on each falling sclk
          if (sclk_fall)
          begin
            sdo_q <= tx_q[7];
            tx_q  <= {tx_q[6:0], 1'b0};
            oe_q  <= 1'b1;
          end
          if (byte_end)
            state_q <= ST_DONE;
        end
        ST_DONE:
          if (sclk_fall)
            oe_q <= 1'b0;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Event detection
  wire [2:0] rd_next    = fifo_rd_ptr + 3'h1;
  wire [2:0] wr_next    = fifo_wr_ptr + 3'h1;
  wire [2:0] fill_level = fifo_wr_ptr - fifo_rd_ptr;

  wire [7:0] set_a;
  wire [7:0] set_b;
  assign set_a[7]                 = 1'b0;
  assign set_a[`EVT_SYNC_LOST]    = sync_lost_evt;
  assign set_a[`EVT_SYNC_LOCKED]  = sync_locked_evt;
  assign set_a[`EVT_SYNC_DONE]    = sync_done_evt;
  assign set_a[`EVT_SYNTH_LOST]   = synth_lost_evt;
  assign set_a[`EVT_SYNTH_LOCKED] = synth_locked_evt;
  assign set_a[`EVT_OVER_THRESH]  = over_threshold_evt;
  assign set_a[`EVT_OUT_SILENCED] = output_silenced_flag;
  assign set_b[7:3]               = 5'h00;
  // Read advance lands on write pointer
  assign set_b[`EVT_FIFO_UNDER] = fifo_rd_adv & (rd_next == fifo_wr_ptr);
  // Write advance lands on read pointer
  assign set_b[`EVT_FIFO_OVER]  = fifo_wr_adv & (wr_next == fifo_rd_ptr);
  assign set_b[`EVT_FIFO_WARN]  = (fill_level <= `FIFO_WARN_LOW) |
                                  (fill_level >= `FIFO_WARN_HIGH);

  // Write-one clears a flag; a new event in the same cycle wins
  wire       clr_a_hit = wr_stb & (addr_q == `ADDR_EVENT_FLAGS_A);
  wire       clr_b_hit = wr_stb & (addr_q == `ADDR_EVENT_FLAGS_B);
  wire [7:0] clr_a     = clr_a_hit ? rx_word : 8'h00;
  wire [7:0] clr_b     = clr_b_hit ? rx_word : 8'h00;
  wire [7:0] flag_a_d  = ((flag_a_q & ~clr_a) | set_a) & `MASK_BANK_A;
  wire [7:0] flag_b_d  = ((flag_b_q & ~clr_b) | set_b) & `MASK_BANK_B;

  // Routed and enabled flags per pin
  wire [7:0] act_a = flag_a_d & en_a_q;
  wire [7:0] act_b = flag_b_d & en_b_q;
  wire       irq_a_d = |(act_a & ~route_a_q) | |(act_b & ~route_b_q);
  wire       irq_b_d = |(act_a & route_a_q) | |(act_b & route_b_q);

  // ==========================================
  // Register file; soft reset acts one cycle after the write
  wire reg_rst = ~resetn | soft_rst_q;

  always @(posedge clk)
  begin
    if (reg_rst)
    begin
      cfg_q      <= `RST_SERIAL_PORT_CONFIG;
      pd_q       <= `RST_POWER_DOWN_CONTROL;
      en_a_q     <= `RST_EVENT_ENABLE;
      en_b_q     <= `RST_EVENT_ENABLE;
      flag_a_q   <= `RST_EVENT_FLAGS;
      flag_b_q   <= `RST_EVENT_FLAGS;
      route_a_q  <= `RST_EVENT_ROUTE;
      route_b_q  <= `RST_EVENT_ROUTE;
      soft_rst_q <= 1'b0;
      irq_a_q    <= 1'b0;
      irq_b_q    <= 1'b0;
    end
    else
    begin
      flag_a_q   <= flag_a_d;
      flag_b_q   <= flag_b_d;
      irq_a_q    <= irq_a_d;
      irq_b_q    <= irq_b_d;
      soft_rst_q <= 1'b0;
      if (wr_stb)
      begin
        case (addr_q)
          `ADDR_SERIAL_PORT_CONFIG:
          begin
            cfg_q      <= rx_word & `MASK_CFG;
            soft_rst_q <= rx_word[`BIT_SOFT_RESET];
          end
          `ADDR_POWER_DOWN_CONTROL:
            pd_q <= rx_word & `MASK_PD;
          `ADDR_EVENT_ENABLE_A:
            en_a_q <= rx_word & `MASK_BANK_A;
          `ADDR_EVENT_ENABLE_B:
            en_b_q <= rx_word & `MASK_BANK_B;
          `ADDR_EVENT_ROUTE_A:
            route_a_q <= rx_word & `MASK_BANK_A;
          `ADDR_EVENT_ROUTE_B:
            route_b_q <= rx_word & `MASK_BANK_B;
          default:
            soft_rst_q <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================
  // Outputs
  assign spi_sdio_o  = sdo_q;
  assign spi_sdio_oe = oe_q;
  assign device_reset = soft_rst_q;

  // Power-down outputs; in-phase and quad offs are analog-only, digital path left running
  assign inphase_analog_off  = pd_q[`BIT_INPHASE_OFF];
  assign quad_analog_off     = pd_q[`BIT_QUAD_OFF];
  assign input_receiver_off  = pd_q[`BIT_RECEIVER_OFF];
  assign whole_chip_off      = pd_q[`BIT_CHIP_OFF];
  assign converter_clock_off = pd_q[`BIT_CLOCK_OFF];
  assign frame_input_off     = pd_q[`BIT_FRAME_OFF];

  // Frame held low while its receiver is off
  assign frame_internal = frame_sync_q[1] & ~pd_q[`BIT_FRAME_OFF];

  assign interrupt_pin_a = irq_a_q;
  assign interrupt_pin_b = irq_b_q;

endmodule // dac_event_irq_and_power_ctrl

// ### verification/dac_irq_checker_properties.sv
// Pin-level assertions for the control and event block.
// Assumes binding into the design top; one clock, reset synchronous.
`timescale 1ns/1ps
module dac_irq_checker
(
  input wire clk,
  input wire resetn,
  input wire spi_cs_n,
  input wire spi_sdio_oe,
  input wire frame_internal,
  input wire inphase_analog_off,
  input wire quad_analog_off,
  input wire input_receiver_off,
  input wire whole_chip_off,
  input wire converter_clock_off,
  input wire frame_input_off,
  input wire device_reset,
  input wire interrupt_pin_a,
  input wire interrupt_pin_b
);
  // ==========================================
  // Helpers and sequences
  default clocking cb @(posedge clk); endclocking
  wire [5:0] pd_w;
  assign pd_w = {inphase_analog_off, quad_analog_off, input_receiver_off,
                 whole_chip_off, converter_clock_off, frame_input_off};
  sequence s_pd_defaults;
    pd_w == 6'h30;
  endsequence
  sequence s_cs_idle;
    spi_cs_n [*5];
  endsequence
  // ==========================================
  // Properties
  property p_pd_reset;
    !resetn |=> s_pd_defaults;
  endproperty
  a_pd_reset: assert property (p_pd_reset)
    else $error("power-down outputs wrong after reset");
  property p_irq_reset;
    !resetn |=> !interrupt_pin_a && !interrupt_pin_b;
  endproperty
  a_irq_reset: assert property (p_irq_reset)
    else $error("interrupt pin high after reset");
  property p_frame_low;
    disable iff (!resetn) frame_input_off |-> !frame_internal;
  endproperty
  a_frame_low: assert property (p_frame_low)
    else $error("frame high while frame input off");
  property p_sr_pulse;
    disable iff (!resetn) device_reset |=> !device_reset;
  endproperty
  a_sr_pulse: assert property (p_sr_pulse)
    else $error("device reset longer than one cycle");
  property p_sr_reload;
    disable iff (!resetn) device_reset |-> ##[1:2] s_pd_defaults;
  endproperty
  a_sr_reload: assert property (p_sr_reload)
    else $error("soft reset did not reload power-down");
  property p_oe_idle;
    disable iff (!resetn) s_cs_idle |-> !spi_sdio_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data line driven outside a frame");
  property p_pd_hold;
    disable iff (!resetn) $changed(pd_w) |-> !$past(spi_cs_n);
  endproperty
  a_pd_hold: assert property (p_pd_hold)
    else $error("power-down changed outside a frame");
  property p_irq_a_fall;
    disable iff (!resetn) $fell(interrupt_pin_a) |-> !$past(spi_cs_n);
  endproperty
  a_irq_a_fall: assert property (p_irq_a_fall)
    else $error("pin a dropped without a register write");
  property p_irq_b_fall;
    disable iff (!resetn) $fell(interrupt_pin_b) |-> !$past(spi_cs_n);
  endproperty
  a_irq_b_fall: assert property (p_irq_b_fall)
    else $error("pin b dropped without a register write");
endmodule // dac_irq_checker

bind dac_event_irq_and_power_ctrl dac_irq_checker dac_irq_checker_i
(
  .clk(clk), .resetn(resetn), .spi_cs_n(spi_cs_n), .spi_sdio_oe(spi_sdio_oe),
  .frame_internal(frame_internal), .inphase_analog_off(inphase_analog_off),
  .quad_analog_off(quad_analog_off), .input_receiver_off(input_receiver_off),
  .whole_chip_off(whole_chip_off), .converter_clock_off(converter_clock_off),
  .frame_input_off(frame_input_off), .device_reset(device_reset),
  .interrupt_pin_a(interrupt_pin_a), .interrupt_pin_b(interrupt_pin_b)
);

// ### verification/spi_host_model.sv
// Serial port host: chip select, serial clock and data line.
// Assumes the device samples on clk; each sclk phase lasts 6 clk.
`timescale 1ns/1ps
module spi_host_model
(
  input  wire clk,
  input  wire sdio_in,
  output reg  cs_n,
  output reg  sclk,
  output reg  sdio_out
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdio_out = 1'b0;
  end
  // One frame: instruction byte then data byte, order set by lsb
  task xfer(input rd, input [6:0] addr, input [7:0] wdata, input lsb,
            output [7:0] rdata);
    reg [15:0] w;
    integer i, j;
    begin
      w = {rd, addr, wdata};
      rdata = 8'h00;
      @(posedge clk);
      cs_n <= 1'b0;
      repeat (3) @(posedge clk);
      for (i = 0; i < 16; i = i + 1)
      begin
        j = lsb ? i % 8 : 7 - i % 8;
        if (rd && i > 7)
          sdio_out <= ~sdio_out; // Released line toggles
        else
          sdio_out <= w[(i < 8 ? 8 : 0) + j];
        repeat (6) @(posedge clk);
        if (rd && i > 7)
          rdata[j] = sdio_in;
        sclk <= 1'b1;
        repeat (6) @(posedge clk);
        sclk <= 1'b0;
      end
      repeat (6) @(posedge clk);
      cs_n <= 1'b1;
      repeat (6) @(posedge clk);
    end
  endtask
endmodule // spi_host_model

// ### verification/tb_top.sv
// Testbench: registers, power-down outputs, events and routing.
// Assumes the host model drives the serial pins.
`timescale 1ns/1ps
`include "dac_irq_defs.vh"
module tb_top;
  reg        clk, resetn, frame_pin, rd_adv, wr_adv, lsb;
  reg  [6:0] evt;
  reg  [2:0] rd_ptr, wr_ptr;
  reg  [7:0] rv;
  wire       cs_n, sclk, host_d, sdio_o, sdio_oe, frame_int, dev_rst, irq_a, irq_b;
  wire [5:0] pd;
  wire       sdio = sdio_oe ? sdio_o : host_d;
  integer    n_errors, compares, n_pulse, k;

  dac_event_irq_and_power_ctrl dac_event_irq_and_power_ctrl_i
  (
    .clk(clk), .resetn(resetn), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdio_i(sdio),
    .spi_sdio_o(sdio_o), .spi_sdio_oe(sdio_oe), .sync_lost_evt(evt[6]),
    .sync_locked_evt(evt[5]), .sync_done_evt(evt[4]), .synth_lost_evt(evt[3]),
    .synth_locked_evt(evt[2]), .over_threshold_evt(evt[1]),
    .output_silenced_flag(evt[0]), .fifo_rd_ptr(rd_ptr), .fifo_wr_ptr(wr_ptr),
    .fifo_rd_adv(rd_adv), .fifo_wr_adv(wr_adv), .frame_pin(frame_pin),
    .frame_internal(frame_int), .inphase_analog_off(pd[5]), .quad_analog_off(pd[4]),
    .input_receiver_off(pd[3]), .whole_chip_off(pd[2]), .converter_clock_off(pd[1]),
    .frame_input_off(pd[0]), .device_reset(dev_rst), .interrupt_pin_a(irq_a),
    .interrupt_pin_b(irq_b)
  );
  spi_host_model spi_host_model_i
  (
    .clk(clk), .sdio_in(sdio), .cs_n(cs_n), .sclk(sclk), .sdio_out(host_d)
  );

  // ==========================================
  // Clock, pulse counter, watchdog
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    if (dev_rst === 1'b1)
      n_pulse <= n_pulse + 1;
  initial
  begin
    #500000;
    n_errors = n_errors + 1;
    complete_run;
  end

  // ==========================================
  // Tasks
  task check(input [7:0] seen, input [7:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  end
  endtask
  task wr_reg(input [6:0] a, input [7:0] d);
    spi_host_model_i.xfer(1'b0, a, d, lsb, rv);
  endtask
  task rd_reg(input [6:0] a, input [7:0] e);
  begin
    spi_host_model_i.xfer(1'b1, a, 8'h00, lsb, rv);
    check(rv, e);
  end
  endtask
  task pulse(input [7:0] m);
  begin
    @(posedge clk);
    evt <= m[6:0];
    @(posedge clk);
    evt <= 7'h00;
    repeat (2) @(posedge clk);
  end
  endtask
  task pins(input [7:0] e);
    check({6'h00, irq_a, irq_b}, e);
  endtask
  task complete_run;
  begin
    $display("Errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    n_errors = 0;
    compares = 0;
    n_pulse = 0;
    lsb = 1'b0;
    resetn = 1'b0;
    frame_pin = 1'b1;
    rd_adv = 1'b0;
    wr_adv = 1'b0;
    evt = 7'h00;
    rd_ptr = 3'h0;
    wr_ptr = 3'h3;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    // Reset values, unmapped offset 0x02 included
    for (k = 0; k < 9; k = k + 1)
      rd_reg(k[6:0], k == 1 ? 8'hc0 : 8'h00);
    check({2'h0, pd}, 8'h30);
    // Each power-down bit alone drives only its own output
    for (k = 0; k < 6; k = k + 1)
    begin
      wr_reg(`ADDR_POWER_DOWN_CONTROL, k > 2 ? 8'h04 << k : 8'h01 << k);
      // Frame pin held high, so frame passes unless its receiver is off
      check({1'b0, frame_int, pd}, (k == 0 ? 8'h00 : 8'h40) | (8'h01 << k));
    end
    wr_reg(`ADDR_POWER_DOWN_CONTROL, 8'hff);
    rd_reg(`ADDR_POWER_DOWN_CONTROL, 8'he7);
    wr_reg(`ADDR_POWER_DOWN_CONTROL, 8'h00);
    check({1'b0, frame_int, pd}, 8'h40);
    // Frame pin low reaches the internal frame after two flops
    frame_pin <= 1'b0;
    repeat (3) @(posedge clk);
    check({7'h00, frame_int}, 8'h00);
    frame_pin <= 1'b1;
    // Disabled event still shows in flags
    pulse(8'h40);
    rd_reg(`ADDR_EVENT_FLAGS_A, 8'h40);
    pins(8'h00);
    wr_reg(`ADDR_EVENT_FLAGS_A, 8'h40);
    wr_reg(`ADDR_EVENT_ENABLE_A, 8'h7f);
    rd_reg(`ADDR_EVENT_ENABLE_A, 8'h7f);
    wr_reg(`ADDR_EVENT_ROUTE_A, 8'h55);
    // Each bank A event: flag, routed pin, clear
    for (k = 0; k < 7; k = k + 1)
    begin
      pulse(8'h01 << k);
      rd_reg(`ADDR_EVENT_FLAGS_A, 8'h01 << k);
      pins(k % 2 == 0 ? 8'h01 : 8'h02);
      wr_reg(`ADDR_EVENT_FLAGS_A, 8'h01 << k);
      pins(8'h00);
    end
    // FIFO underflow with warning, then overflow with warning
    wr_reg(`ADDR_EVENT_ENABLE_B, 8'h07);
    rd_reg(`ADDR_EVENT_ENABLE_B, 8'h07);
    wr_reg(`ADDR_EVENT_ROUTE_B, 8'h02);
    rd_reg(`ADDR_EVENT_FLAGS_B, 8'h00);
    @(posedge clk);
    rd_ptr <= 3'h2;
    rd_adv <= 1'b1;
    @(posedge clk);
    rd_adv <= 1'b0;
    rd_reg(`ADDR_EVENT_FLAGS_B, 8'h05);
    pins(8'h02);
    rd_ptr <= 3'h0;
    wr_ptr <= 3'h4;
    wr_reg(`ADDR_EVENT_FLAGS_B, 8'h07);
    rd_reg(`ADDR_EVENT_FLAGS_B, 8'h00);
    @(posedge clk);
    wr_ptr <= 3'h7;
    wr_adv <= 1'b1;
    @(posedge clk);
    wr_adv <= 1'b0;
    rd_reg(`ADDR_EVENT_FLAGS_B, 8'h03);
    pins(8'h03);
    // Bit order switch, then soft reset
    wr_reg(`ADDR_SERIAL_PORT_CONFIG, 8'h40);
    lsb = 1'b1;
    rd_reg(`ADDR_SERIAL_PORT_CONFIG, 8'h40);
    wr_reg(`ADDR_EVENT_ROUTE_A, 8'h0f);
    rd_reg(`ADDR_EVENT_ROUTE_A, 8'h0f);
    wr_reg(`ADDR_SERIAL_PORT_CONFIG, 8'h60);
    lsb = 1'b0;
    check(n_pulse[7:0], 8'h01);
    rd_reg(`ADDR_SERIAL_PORT_CONFIG, 8'h00);
    rd_reg(`ADDR_POWER_DOWN_CONTROL, 8'hc0);
    rd_reg(`ADDR_EVENT_ROUTE_A, 8'h00);
    complete_run;
  end
endmodule // tb_top
